// *** rtl/cps_pkg.sv ***
// shared constants and types of the compressor protection supervisor
package cps_pkg;
	// clock and time base
	localparam int CPS_CLK_PERIOD_NS = 10;
	localparam int CPS_SEC_NS = 1000000000;
	localparam int CPS_SEC_CYC = CPS_SEC_NS / CPS_CLK_PERIOD_NS;
	localparam int CPS_S_PER_MIN = 60;
	// protection times, as printed, and their second counts
	localparam int CPS_MIN_OFF_MIN = 3;
	localparam int CPS_MIN_OFF_S = CPS_MIN_OFF_MIN * CPS_S_PER_MIN;
	localparam int CPS_MIN_RUN_S = 30;
	localparam int CPS_PEAK_SHORT_S = 30;
	localparam int CPS_PEAK_LONG_MIN = 2;
	localparam int CPS_PEAK_LONG_S = CPS_PEAK_LONG_MIN * CPS_S_PER_MIN;
	localparam int CPS_PEAK_QUICK_MIN = 1;
	localparam int CPS_PEAK_QUICK_S = CPS_PEAK_QUICK_MIN * CPS_S_PER_MIN;
	localparam int CPS_PEAK_REPEATS = 7;
	localparam int CPS_OC_WIN_MIN = 20;
	localparam int CPS_OC_LIMIT = 3;
	localparam int CPS_IPM_WIN_MIN = 30;
	localparam int CPS_IPM_LIMIT = 3;
	localparam int CPS_SHELL_WIN_MIN = 30;
	localparam int CPS_SHELL_LIMIT = 4;
	localparam int CPS_LF_RUN_MIN = 240;
	localparam int CPS_LF_RUN_S = CPS_LF_RUN_MIN * CPS_S_PER_MIN;
	localparam int CPS_LF_HOLD_MIN = 2;
	localparam int CPS_LF_HOLD_S = CPS_LF_HOLD_MIN * CPS_S_PER_MIN;
	localparam int CPS_PRESS_ARM_MIN = 5;
	localparam int CPS_PRESS_ARM_S = CPS_PRESS_ARM_MIN * CPS_S_PER_MIN;
	localparam int CPS_PRESS_HOLD_S = 5;
	// temperatures in 0.1 degC, signed
	localparam logic signed [11:0] CPS_IPM_TRIP_T = 12'sh3b6;
	localparam logic signed [11:0] CPS_IPM_COOL_T = 12'sh384;
	localparam logic signed [11:0] CPS_SHELL_TRIP_T = 12'sh460;
	localparam logic signed [11:0] CPS_CCH_ON_AIR_T = 12'sh028;
	localparam logic signed [11:0] CPS_CCH_ON_DIS_T = 12'sh074;
	localparam logic signed [11:0] CPS_CCH_OFF_AIR_T = 12'sh03c;
	localparam logic signed [11:0] CPS_CCH_OFF_DIS_T = 12'sh0bc;
	localparam logic signed [11:0] CPS_LF_WATER_LO_T = 12'sh08c;
	localparam logic signed [11:0] CPS_LF_WATER_HI_T = 12'sh1e0;
	localparam logic signed [11:0] CPS_LF_AIR_LO_T = 12'sh028;
	localparam logic signed [11:0] CPS_LF_AIR_HI_T = 12'sh0f0;
	localparam logic signed [11:0] CPS_LF_HX_MIN_T = 12'sh000;
	// running current in 0.1 A, frequency in Hz, pressure in adc codes
	localparam logic [7:0] CPS_CUR_X = 8'h3e;
	localparam logic [7:0] CPS_CUR_Y = 8'h6a;
	localparam logic [7:0] CPS_LF_FREQ = 8'h19;
	localparam logic [9:0] CPS_PRESS_HI = 10'h3fc;
	localparam logic [9:0] CPS_PRESS_LO = 10'h003;

	typedef enum logic [1:0] {
		CPS_ST_WAIT = 2'b00,
		CPS_ST_READY = 2'b01,
		CPS_ST_RUN = 2'b10
	} cps_state_type;

	typedef enum logic [1:0] {
		CPS_FREQ_NORMAL = 2'b00,
		CPS_FREQ_REDUCED = 2'b01,
		CPS_FREQ_FORCE24 = 2'b10
	} cps_freq_type;

	typedef enum logic [2:0] {
		CPS_FAULT_NONE = 3'h0,
		CPS_FAULT_OVERCURRENT = 3'h1,
		CPS_FAULT_POWER_STAGE_OVERHEAT = 3'h2,
		CPS_FAULT_PEAK_CURRENT = 3'h3,
		CPS_FAULT_SHELL_OVERHEAT = 3'h4,
		CPS_FAULT_PRESSURE_SENSOR = 3'h5
	} cps_fault_type;

	typedef struct packed {
		logic user_on;
		logic run_req;
		logic peak_over;
		logic [7:0] run_cur;
		logic [7:0] comp_freq;
		logic [9:0] press;
		logic signed [11:0] ipm_temp;
		logic signed [11:0] shell_temp;
		logic signed [11:0] water_out;
		logic signed [11:0] air_out;
		logic signed [11:0] hx_in;
		logic signed [11:0] discharge;
	} cps_sense_type;
endpackage

// *** rtl/cps_supervisor.sv ***
// compressor protection supervisor: start/stop guard, trips, lockouts, heater
// Function
// - after a stop, block compressor start for three minutes
// - once started, ignore internal stop requests for 30 seconds
// - user stop overrides minimum run and halts at once
// - current above first threshold requests reduced frequency, else normal
// - current above second threshold stops; third within 20 minutes locks out
// - power stage at 95 degC stops compressor at once
// - restart 3 minutes after cooling to 90; three in 30 minutes lock out
// - peak current over model limit stops, restart after three minutes
// - peak repeat later than 30 s after restart resumes after two minutes
// - repeat within 30 s resumes after one minute; seven repeats lock out
// - shell above 112 degC stops; four in 30 minutes lock out
// - below 25 Hz for 240 minutes commands 24 Hz for 2 minutes
// - reduce frequency when water, air and exchanger conditions all hold
// - pressure supervision only after 5 minutes of compressor run
// - pressure at rail or open for 5 s stops and flags fault
// - crank heater on when air and discharge both cold enough
// - crank heater off when air or discharge too warm
// - indicator blinks while any lockout is active
`timescale 1ns/1ps
module cps_supervisor #(
	parameter int SEC_CYCLES = cps_pkg::CPS_SEC_CYC,
	parameter logic [7:0] CUR_X = cps_pkg::CPS_CUR_X,
	parameter logic [7:0] CUR_Y = cps_pkg::CPS_CUR_Y
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// sensors and operator, asynchronous to MCLK
	input wire cps_pkg::cps_sense_type SENSE,
	// compressor drive
	output logic COMP_RUN,
	output cps_pkg::cps_freq_type FREQ_CMD,
	// heater and indication
	output logic CRANK_HEAT,
	output logic LED_ON,
	output logic LOCKOUT,
	output cps_pkg::cps_fault_type FAULT_CODE
);
	import cps_pkg::*;

	localparam int NW = 3;
	localparam logic [10:0] WIN_S [NW] = '{11'(CPS_OC_WIN_MIN * CPS_S_PER_MIN),
		11'(CPS_IPM_WIN_MIN * CPS_S_PER_MIN), 11'(CPS_SHELL_WIN_MIN * CPS_S_PER_MIN)};
	localparam logic [2:0] WIN_LIMIT [NW] = '{3'(CPS_OC_LIMIT), 3'(CPS_IPM_LIMIT), 3'(CPS_SHELL_LIMIT)};

	cps_sense_type s;
	cps_sync #(.W($bits(cps_sense_type))) u_sync (
		.clk(MCLK),
		.rst_n(RESETN),
		.d(SENSE),
		.q(s)
	);

	// one second time base
	logic [31:0] pre_reg;
	logic tick_reg;
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			pre_reg <= 32'h0;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (pre_reg == 32'(SEC_CYCLES - 1));
			pre_reg <= (pre_reg == 32'(SEC_CYCLES - 1)) ? 32'h0 : pre_reg + 32'h1;
		end
	end

	cps_state_type state_reg, state_next;
	logic [8:0] delay_reg, delay_next;
	logic [8:0] run_s_reg;
	logic [8:0] off_s_reg;
	logic ipm_hot_reg;
	logic peak_seen_reg;
	logic [2:0] peak_cnt_reg;
	logic lock_reg;
	cps_fault_type fault_reg;
	logic [2:0] press_s_reg;
	logic [13:0] lf_s_reg;
	logic [6:0] force_s_reg;
	logic heat_reg;
	logic blink_reg;
	logic led_reg;
	cps_freq_type freq_reg;

	// trip decode
	wire running = (state_reg == CPS_ST_RUN);
	wire oc_trip = running && (s.run_cur > CUR_Y);
	wire ipm_trip = running && (s.ipm_temp >= CPS_IPM_TRIP_T);
	wire ipm_cool = ipm_hot_reg && (s.ipm_temp <= CPS_IPM_COOL_T);
	wire peak_trip = running && s.peak_over;
	wire shell_trip = running && (s.shell_temp > CPS_SHELL_TRIP_T);
	wire press_armed = running && (run_s_reg >= 9'(CPS_PRESS_ARM_S));
	wire press_bad = press_armed && (s.press >= CPS_PRESS_HI || s.press <= CPS_PRESS_LO);
	wire press_trip = press_bad && tick_reg && (press_s_reg == 3'(CPS_PRESS_HOLD_S - 1));
	wire peak_quick = peak_seen_reg && (run_s_reg < 9'(CPS_PEAK_SHORT_S));
	wire peak_lock = peak_trip && peak_quick && (peak_cnt_reg == 3'(CPS_PEAK_REPEATS - 1));
	wire [NW-1:0] win_ev = {shell_trip, ipm_trip, oc_trip};
	wire [NW-1:0] win_hit;
	wire lock_set = (|win_hit) || peak_lock || press_trip;
	wire trip_any = oc_trip || ipm_trip || peak_trip || shell_trip || press_trip;
	wire min_run_done = run_s_reg >= 9'(CPS_MIN_RUN_S);
	wire stop_now = trip_any || !s.user_on || (!s.run_req && min_run_done);
	wire start_ok = s.user_on && s.run_req && !lock_reg && !ipm_hot_reg;

	// restart delay chosen by the cause of the stop
	wire [8:0] stop_delay = !peak_trip ? 9'(CPS_MIN_OFF_S) :
		!peak_seen_reg ? 9'(CPS_MIN_OFF_S) :
		peak_quick ? 9'(CPS_PEAK_QUICK_S) :
		9'(CPS_PEAK_LONG_S);

	always_comb begin
		state_next = state_reg;
		delay_next = delay_reg;
		unique case (state_reg)
			CPS_ST_WAIT: begin
				if (ipm_cool) begin
					delay_next = 9'(CPS_MIN_OFF_S);
				end else if (delay_reg == 9'h0) begin
					state_next = ipm_hot_reg ? CPS_ST_WAIT : CPS_ST_READY;
				end else if (tick_reg) begin
					delay_next = delay_reg - 9'h1;
				end
			end
			CPS_ST_READY: begin
				if (start_ok) begin
					state_next = CPS_ST_RUN;
				end
			end
			CPS_ST_RUN: begin
				// protection and user stops act at once; plain demand loss waits
				if (stop_now) begin
					state_next = CPS_ST_WAIT;
					delay_next = stop_delay;
				end
			end
			default: begin
				state_next = CPS_ST_WAIT;
				delay_next = 9'(CPS_MIN_OFF_S);
			end
		endcase
	end

	// power-up counts as a stop, so the first start also waits
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= CPS_ST_WAIT;
			delay_reg <= 9'(CPS_MIN_OFF_S);
			COMP_RUN <= 1'b0;
		end else begin
			state_reg <= state_next;
			delay_reg <= delay_next;
			COMP_RUN <= (state_next == CPS_ST_RUN);
		end
	end

	// run and off second counters, saturating
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			run_s_reg <= 9'h0;
			off_s_reg <= 9'h0;
		end else begin
			if (!running) begin
				run_s_reg <= 9'h0;
			end else if (tick_reg && run_s_reg != 9'h1ff) begin
				run_s_reg <= run_s_reg + 9'h1;
			end
			if (running) begin
				off_s_reg <= 9'h0;
			end else if (tick_reg && off_s_reg != 9'h1ff) begin
				off_s_reg <= off_s_reg + 9'h1;
			end
		end
	end

	// power stage overheat latch and peak current repeat tracking
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			ipm_hot_reg <= 1'b0;
			peak_seen_reg <= 1'b0;
			peak_cnt_reg <= 3'h0;
		end else begin
			if (ipm_trip) begin
				ipm_hot_reg <= 1'b1;
			end else if (ipm_cool) begin
				ipm_hot_reg <= 1'b0;
			end
			if (peak_trip) begin
				peak_seen_reg <= 1'b1;
				peak_cnt_reg <= peak_quick ? peak_cnt_reg + 3'h1 : 3'h0;
			end else if (!s.user_on) begin
				peak_seen_reg <= 1'b0;
				peak_cnt_reg <= 3'h0;
			end
		end
	end

	// windowed trip counters: window opens on first trip, count drops when it lapses
	genvar g;
	generate
		for (g = 0; g < NW; g++) begin : g_win
			logic [10:0] win_reg;
			logic [2:0] cnt_reg;
			assign win_hit[g] = win_ev[g] && (win_reg != 11'h0) && (cnt_reg + 3'h1 >= WIN_LIMIT[g]);
			always_ff @(posedge MCLK or negedge RESETN) begin
				if (!RESETN) begin
					win_reg <= 11'h0;
					cnt_reg <= 3'h0;
				end else if (win_ev[g]) begin
					if (win_reg == 11'h0) begin
						win_reg <= WIN_S[g];
						cnt_reg <= 3'h1;
					end else begin
						cnt_reg <= cnt_reg + 3'h1;
					end
				end else if (!s.user_on) begin
					win_reg <= 11'h0;
					cnt_reg <= 3'h0;
				end else if (tick_reg && win_reg != 11'h0) begin
					win_reg <= win_reg - 11'h1;
					if (win_reg == 11'h1) begin
						cnt_reg <= 3'h0;
					end
				end
			end
		end
	endgenerate

	// pressure hold timer
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			press_s_reg <= 3'h0;
		end else if (!press_bad) begin
			press_s_reg <= 3'h0;
		end else if (tick_reg && press_s_reg != 3'h7) begin
			press_s_reg <= press_s_reg + 3'h1;
		end
	end

	// lockout and fault code; a new lockout wins over the user clear
	cps_fault_type fault_new;
	assign fault_new = win_hit[0] ? CPS_FAULT_OVERCURRENT :
		win_hit[1] ? CPS_FAULT_POWER_STAGE_OVERHEAT :
		win_hit[2] ? CPS_FAULT_SHELL_OVERHEAT :
		peak_lock ? CPS_FAULT_PEAK_CURRENT : CPS_FAULT_PRESSURE_SENSOR;
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			lock_reg <= 1'b0;
			fault_reg <= CPS_FAULT_NONE;
		end else if (lock_set && !lock_reg) begin
			lock_reg <= 1'b1;
			fault_reg <= fault_new;
		end else if (!s.user_on && !lock_set) begin
			lock_reg <= 1'b0;
			fault_reg <= CPS_FAULT_NONE;
		end
	end

	// low frequency run timer and 24 Hz hold
	wire lf_run = running && (s.comp_freq < CPS_LF_FREQ) && (force_s_reg == 7'h0);
	wire lf_fire = lf_run && tick_reg && (lf_s_reg == 14'(CPS_LF_RUN_S - 1));
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			lf_s_reg <= 14'h0;
			force_s_reg <= 7'h0;
		end else begin
			if (!lf_run || lf_fire) begin
				lf_s_reg <= 14'h0;
			end else if (tick_reg) begin
				lf_s_reg <= lf_s_reg + 14'h1;
			end
			if (!running) begin
				force_s_reg <= 7'h0;
			end else if (lf_fire) begin
				force_s_reg <= 7'(CPS_LF_HOLD_S);
			end else if (tick_reg && force_s_reg != 7'h0) begin
				force_s_reg <= force_s_reg - 7'h1;
			end
		end
	end

	// frequency request
	wire lf_env = (s.water_out < CPS_LF_WATER_LO_T || s.water_out >= CPS_LF_WATER_HI_T) &&
		(s.air_out < CPS_LF_AIR_LO_T || s.air_out >= CPS_LF_AIR_HI_T) &&
		(s.hx_in >= CPS_LF_HX_MIN_T);
	wire cur_high = s.run_cur > CUR_X;
	cps_freq_type freq_next;
	assign freq_next = (force_s_reg != 7'h0) ? CPS_FREQ_FORCE24 :
		(cur_high || lf_env) ? CPS_FREQ_REDUCED : CPS_FREQ_NORMAL;

	// crank case heater, hysteresis between on and off points
	wire heat_on = (s.air_out <= CPS_CCH_ON_AIR_T) && (s.discharge <= CPS_CCH_ON_DIS_T);
	wire heat_off = (s.air_out > CPS_CCH_OFF_AIR_T) || (s.discharge > CPS_CCH_OFF_DIS_T);

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			freq_reg <= CPS_FREQ_NORMAL;
			heat_reg <= 1'b0;
			blink_reg <= 1'b0;
			led_reg <= 1'b0;
		end else begin
			freq_reg <= freq_next;
			if (heat_on) begin
				heat_reg <= 1'b1;
			end else if (heat_off) begin
				heat_reg <= 1'b0;
			end
			if (tick_reg) begin
				blink_reg <= ~blink_reg;
			end
			led_reg <= lock_reg ? blink_reg : s.user_on;
		end
	end

	assign FREQ_CMD = freq_reg;
	assign CRANK_HEAT = heat_reg;
	assign LED_ON = led_reg;
	assign LOCKOUT = lock_reg;
	assign FAULT_CODE = fault_reg;

	sequence s_run_young;
		COMP_RUN && running && !min_run_done && s.user_on;
	endsequence
	sequence s_no_trip;
		!trip_any && !ipm_hot_reg;
	endsequence

	a_min_off_hold: assert property (@(posedge MCLK) disable iff (!RESETN)
		$rose(COMP_RUN) && !peak_seen_reg |-> off_s_reg >= 9'(CPS_MIN_OFF_S))
		else $error("compressor started before minimum off time");
	a_min_run_hold: assert property (@(posedge MCLK) disable iff (!RESETN)
		s_run_young and s_no_trip |=> COMP_RUN)
		else $error("compressor stopped inside minimum run time");
	a_user_stop: assert property (@(posedge MCLK) disable iff (!RESETN)
		running && !s.user_on |=> !COMP_RUN ##1 !COMP_RUN)
		else $error("user stop did not halt compressor");
	a_reduce_freq: assert property (@(posedge MCLK) disable iff (!RESETN)
		cur_high && force_s_reg == 7'h0 |=> FREQ_CMD == CPS_FREQ_REDUCED)
		else $error("high current did not reduce frequency");
	a_overheat_stop: assert property (@(posedge MCLK) disable iff (!RESETN)
		ipm_trip |=> !COMP_RUN && ipm_hot_reg)
		else $error("power stage overheat did not stop compressor");
	a_press_gate: assert property (@(posedge MCLK) disable iff (!RESETN)
		press_trip |-> run_s_reg >= 9'(CPS_PRESS_ARM_S) && $past(press_bad, 1))
		else $error("pressure fault outside detection period");
	a_heater_on: assert property (@(posedge MCLK) disable iff (!RESETN)
		heat_on |=> CRANK_HEAT)
		else $error("crank heater not switched on");
	a_heater_off: assert property (@(posedge MCLK) disable iff (!RESETN)
		heat_off && !heat_on |=> !CRANK_HEAT)
		else $error("crank heater not switched off");
	a_lockout_hold: assert property (@(posedge MCLK) disable iff (!RESETN)
		LOCKOUT && s.user_on |=> LOCKOUT && FAULT_CODE == $past(FAULT_CODE))
		else $error("lockout released while operation on");
	a_lockout_blink: assert property (@(posedge MCLK) disable iff (!RESETN)
		LOCKOUT && $past(LOCKOUT) |=> LED_ON == $past(blink_reg))
		else $error("indicator not blinking during lockout");
endmodule

// *** rtl/cps_sync.sv ***
// two-stage synchroniser for a bundle of slow sensor inputs
`timescale 1ns/1ps
module cps_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// sensor words change slowly; a torn word lasts one cycle at most
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// *** verif/cps_plant_model.sv ***
// far-side model: inverter drive and sensors seen by the supervisor
`timescale 1ns/1ps
module cps_plant_model (
	// drive state from the supervisor
	input wire logic comp_run,
	// conditions asked for by the bench
	input wire cps_pkg::cps_sense_type cmd,
	// sensor bundle to the supervisor
	output cps_pkg::cps_sense_type sense
);
	import cps_pkg::*;
	// a stopped compressor draws no current and cools at once, so trips are re-armed per start
	always_comb begin
		sense = cmd;
		if (!comp_run) begin
			sense.peak_over = 1'b0;
			sense.run_cur = 8'h00;
			sense.comp_freq = 8'h00;
			sense.ipm_temp = 12'h1f4;
			sense.shell_temp = 12'h190;
		end
	end
endmodule

// *** verif/tb_compressor_protection_supervisor.sv ***
// self-checking bench of the compressor protection supervisor
`timescale 1ns/1ps
module tb_compressor_protection_supervisor;
	import cps_pkg::*;
	// short second so the long protection times fit the run
	localparam int SEC = 2;
	logic mclk = 1'b0;
	logic resetn;
	logic comp_run;
	logic crank_heat;
	logic led_on;
	logic lockout;
	cps_freq_type freq_cmd;
	cps_fault_type fault_code;
	cps_sense_type cmd;
	cps_sense_type sense;
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;
	int heat_m = 0;

	cps_supervisor #(.SEC_CYCLES(SEC)) DUT (.MCLK(mclk), .RESETN(resetn), .SENSE(sense), .COMP_RUN(comp_run),
		.FREQ_CMD(freq_cmd), .CRANK_HEAT(crank_heat), .LED_ON(led_on), .LOCKOUT(lockout), .FAULT_CODE(fault_code));
	cps_plant_model PLANT (.comp_run(comp_run), .cmd(cmd), .sense(sense));

	always #5 mclk = ~mclk;

	task automatic final_report;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chkv(input string what, input logic [3:0] e, input logic [3:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", what, e, g);
		end
	endtask

	// times are whole seconds; the tick phase of the design is unknown, hence the slack
	task automatic chkt(input string what, input int e, input int g);
		checks++;
		if (g < e - 3 || g > e + 3) begin
			n_mismatch++;
			$display("wrong value %s expected %0d seen %0d", what, e, g);
		end
	endtask

	task automatic wait_for(input int sel, input logic [3:0] v, input int max_s, output int s);
		int n;
		n = 0;
		while ((sel == 0 ? {3'b000, comp_run} : {2'b00, freq_cmd}) !== v && n < max_s * SEC) begin
			tick(1);
			n++;
		end
		s = n / SEC;
	endtask

	function automatic logic [3:0] exp_freq(input cps_sense_type s);
		int w;
		int a;
		int h;
		w = s.water_out;
		a = s.air_out;
		h = s.hx_in;
		if (s.run_cur > 62 || ((w < 140 || w >= 480) && (a < 40 || a >= 240) && h >= 0)) begin
			return 4'h1;
		end
		return 4'h0;
	endfunction

	task automatic neutral;
		cmd.run_cur = 8'h1e;
		cmd.comp_freq = 8'h32;
		cmd.press = 10'h200;
		cmd.ipm_temp = 12'h1f4;
		cmd.shell_temp = 12'h190;
		cmd.water_out = 12'h12c;
		cmd.air_out = 12'h064;
		cmd.hx_in = 12'h032;
		cmd.discharge = 12'h12c;
		cmd.peak_over = 1'b0;
	endtask

	// e: seconds of off time still owed when the operator switches on
	task automatic restart(input int e);
		int t;
		cmd.user_on = 1'b1;
		wait_for(0, 4'h1, 200, t);
		chkt("start delay", e, t);
	endtask

	// fault held by the bench: every start trips at once until the lockout
	task automatic series(input int n, input logic [3:0] code, input int d[$]);
		int t;
		logic s0;
		logic s1;
		for (int k = 0; k < n; k++) begin
			tick(4);
			chkv("trip stop", 4'h0, {3'b000, comp_run});
			if (k < n - 1) begin
				wait_for(0, 4'h1, d[k] + 10, t);
				chkt("trip restart", d[k], t);
			end
		end
		chkv("lockout", {1'b1, code[2:0]}, {lockout, fault_code});
		s0 = 1'b0;
		s1 = 1'b0;
		repeat (3 * SEC) begin
			tick(1);
			s0 = s0 | (led_on === 1'b0);
			s1 = s1 | (led_on === 1'b1);
		end
		chkv("blink", 4'h3, {2'b00, s1, s0});
		wait_for(0, 4'h1, 200, t);
		chkv("held", 4'h2, {2'b00, lockout, comp_run});
		cmd.user_on = 1'b0;
		tick(4);
		chkv("cleared", 4'h0, {lockout, fault_code});
	endtask

	initial begin
		int t;
		int a;
		int ds;
		cmd.user_on = 1'b0;
		cmd.run_req = 1'b0;
		neutral();
		resetn = 1'b0;
		void'($urandom(8));
		tick(6);
		chkv("reset", 4'h0, {comp_run, lockout, crank_heat, led_on});
		resetn = 1'b1;
		cmd.run_req = 1'b1;
		restart(180);
		chkv("led steady", 4'h1, {3'b000, led_on});
		cmd.run_req = 1'b0;
		wait_for(0, 4'h0, 60, t);
		chkt("min run", 30, t);
		cmd.run_req = 1'b1;
		wait_for(0, 4'h1, 200, t);
		chkt("stop delay", 180, t);
		tick(5 * SEC);
		cmd.user_on = 1'b0;
		tick(4);
		chkv("user stop", 4'h0, {3'b000, comp_run});
		restart(180);
		for (int i = 0; i < 40; i++) begin
			cmd.run_cur = 8'($urandom_range(106, 0));
			cmd.water_out = 12'($urandom_range(600, 0)) - 12'h032;
			cmd.air_out = 12'($urandom_range(350, 0)) - 12'h032;
			cmd.hx_in = 12'($urandom_range(150, 0)) - 12'h032;
			cmd.discharge = 12'($urandom_range(250, 50));
			tick(5);
			chkv("freq", exp_freq(sense), {2'b00, freq_cmd});
			a = sense.air_out;
			ds = sense.discharge;
			if (a <= 40 && ds <= 116) begin
				heat_m = 1;
			end else if (a > 60 || ds > 188) begin
				heat_m = 0;
			end
			chkv("heater", 4'(heat_m), {3'b000, crank_heat});
		end
		neutral();
		tick(1);
		// two trips, then let the window lapse before the real series
		cmd.run_cur = 8'h6b;
		tick(4);
		wait_for(0, 4'h1, 200, t);
		chkt("oc restart", 180, t);
		tick(4);
		cmd.run_cur = 8'h1e;
		wait_for(0, 4'h1, 200, t);
		chkt("oc restart", 180, t);
		tick(1300 * SEC);
		cmd.run_cur = 8'h6b;
		series(3, {1'b0, CPS_FAULT_OVERCURRENT}, '{180, 180});
		neutral();
		// last stop lies minutes back, so the start comes at once
		restart(0);
		cmd.ipm_temp = 12'h3b6;
		series(3, {1'b0, CPS_FAULT_POWER_STAGE_OVERHEAT}, '{180, 180});
		neutral();
		restart(0);
		cmd.shell_temp = 12'h461;
		series(4, {1'b0, CPS_FAULT_SHELL_OVERHEAT}, '{180, 180, 180});
		neutral();
		restart(0);
		cmd.peak_over = 1'b1;
		tick(4);
		chkv("peak stop", 4'h0, {3'b000, comp_run});
		wait_for(0, 4'h1, 200, t);
		chkt("peak first", 180, t);
		tick(4);
		chkv("peak quick stop", 4'h0, {3'b000, comp_run});
		cmd.peak_over = 1'b0;
		wait_for(0, 4'h1, 80, t);
		chkt("peak quick", 60, t);
		tick(40 * SEC);
		cmd.peak_over = 1'b1;
		series(8, {1'b0, CPS_FAULT_PEAK_CURRENT}, '{120, 60, 60, 60, 60, 60, 60});
		neutral();
		restart(0);
		cmd.press = 10'h3ff;
		wait_for(0, 4'h0, 320, t);
		chkt("press trip", 305, t);
		tick(4);
		chkv("press code", {1'b0, CPS_FAULT_PRESSURE_SENSOR}, {1'b0, fault_code});
		cmd.user_on = 1'b0;
		cmd.press = 10'h200;
		tick(4);
		// the trip stop was four seconds before the switch-on
		restart(176);
		cmd.comp_freq = 8'h14;
		wait_for(1, 4'h2, 14500, t);
		chkt("low freq run", 14400, t);
		wait_for(1, 4'h0, 200, t);
		chkt("low freq hold", 120, t);
		final_report();
	end
endmodule
